// ===== enc_out_pkg.sv
// constants shared by the encoder pulse output block: register map, field layout, modes and timing
// assumes a 125 MHz control clock and a 32-bit AXI4-Lite register port
`default_nettype none
package enc_out_pkg;
  // clock and timing
  localparam int unsigned CLK_KHZ        = 125000;   // control clock rate in kHz
  localparam int unsigned MAX_RATE_KPPS  = 4600;     // output pulse ceiling, kpulses/s
  // least spacing between two quadrature edges, rounded up to whole cycles
  localparam int unsigned EDGE_GAP_CYC   = (CLK_KHZ + MAX_RATE_KPPS - 1) / MAX_RATE_KPPS;
  localparam int unsigned ZERO_MIN_US    = 400;      // zero-point pulse least width, microseconds
  localparam int unsigned ZERO_MIN_CYC   = (ZERO_MIN_US * CLK_KHZ + 999) / 1000;

  // register byte offsets
  localparam logic [7:0] REG_CTRL        = 8'h00;    // phase select, scaling mode
  localparam logic [7:0] REG_PULSE_CNT   = 8'h04;    // output_pulse_count_cfg
  localparam logic [7:0] REG_PULSE_GEAR  = 8'h08;    // output_pulse_gear_cfg
  localparam logic [7:0] REG_MON_SEL     = 8'h0c;    // monitor channel selections
  localparam logic [7:0] REG_STATUS      = 8'h10;    // live state, read only

  // field positions
  localparam int unsigned CTRL_PHASE_BIT = 0;        // phase relation swap
  localparam int unsigned CTRL_MODE_LSB  = 4;        // scaling mode, two bits
  localparam int unsigned MON1_SEL_LSB   = 0;        // monitor 1 source, two bits
  localparam int unsigned MON2_SEL_LSB   = 8;        // monitor 2 source, two bits
  localparam int unsigned STAT_A_BIT     = 0;
  localparam int unsigned STAT_B_BIT     = 1;
  localparam int unsigned STAT_Z_BIT     = 2;
  localparam int unsigned STAT_PEND_LSB  = 16;       // pending edge count, 16 bits

  // reset values
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0] PULSE_CNT_RST  = 32'h0000_1000;
  localparam logic [31:0] PULSE_GEAR_RST = 32'h0000_0001;
  localparam logic [31:0] MON_SEL_RST    = 32'h0000_0100;

  // scaling modes
  typedef enum logic [1:0] {
    MODE_COUNT = 2'h0,                               // edges per revolution given directly
    MODE_DIV   = 2'h1,                               // encoder counts divided by a ratio
    MODE_GEAR  = 2'h2                                // numerator / denominator gear
  } scale_mode_t;

  // bus answers
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  localparam int unsigned MON_SRC_W      = 16;       // monitor source width
  localparam int unsigned MON_OUT_W      = 10;       // monitor resolution
endpackage : enc_out_pkg
`default_nettype wire

// ===== zero_pulse_stretch.sv
// zero-point pulse shaper: follows the zero-position level and stretches it to a least width
// assumes zero_level comes from logic on aclk, no synchroniser needed
`default_nettype none
module zero_pulse_stretch
  import enc_out_pkg::*;
#(
  parameter int unsigned MIN_CYC = ZERO_MIN_CYC      // least pulse width in cycles
) (
  input  wire logic aclk,                            // control clock
  input  wire logic aresetn,                         // synchronous reset, active low
  input  wire logic zero_level,                      // motor at zero-point position
  output logic      pulse_q                          // shaped zero pulse
);
  logic        level_q;                              // previous level, for edge detect
  logic [31:0] hold_q;                               // remaining stretch cycles

  // edge detect and stretch timer; a new edge restarts the full width
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= 1'b0;
      hold_q  <= 32'h0;
    end else begin
      level_q <= zero_level;
      if (zero_level && !level_q) begin
        hold_q <= MIN_CYC - 1;
      end else if (hold_q != 32'h0) begin
        hold_q <= hold_q - 32'h1;
      end
    end
  end

  // high while at zero position or still inside the least width
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= zero_level || (hold_q != 32'h0);
    end
  end
endmodule : zero_pulse_stretch
`default_nettype wire

// ===== encoder_pulse_and_monitor_out.sv
// encoder emulation outputs: scaled quadrature pair, zero-point pulses, two monitor codes
// assumes enc_step/enc_dir/enc_zero and monitor sources come from control logic on aclk
`default_nettype none
module encoder_pulse_and_monitor_out
  import enc_out_pkg::*;
#(
  parameter int unsigned ENC_COUNTS_REV = 4096,      // encoder counts per revolution
  parameter int unsigned ZERO_MIN       = ZERO_MIN_CYC // zero pulse least width, cycles
) (
  input  wire logic                 aclk,            // 125 MHz control clock
  input  wire logic                 aresetn,         // synchronous reset, active low
  // axi4-lite slave
  input  wire logic [7:0]           awaddr,          // write address
  input  wire logic                 awvalid,         // write address valid
  output logic                      awready,         // write address ready
  input  wire logic [31:0]          wdata,           // write data
  input  wire logic [3:0]           wstrb,           // write byte strobes
  input  wire logic                 wvalid,          // write data valid
  output logic                      wready,          // write data ready
  output logic [1:0]                bresp,           // write response
  output logic                      bvalid,          // write response valid
  input  wire logic                 bready,          // write response ready
  input  wire logic [7:0]           araddr,          // read address
  input  wire logic                 arvalid,         // read address valid
  output logic                      arready,         // read address ready
  output logic [31:0]               rdata,           // read data
  output logic [1:0]                rresp,           // read response
  output logic                      rvalid,          // read data valid
  input  wire logic                 rready,          // read data ready
  // motion source
  input  wire logic                 enc_step,        // one encoder count moved
  input  wire logic                 enc_dir,         // 1 = counter-clockwise
  input  wire logic                 enc_zero,        // at zero-point position
  input  wire logic [4*MON_SRC_W-1:0] mon_src,       // four signed monitor sources
  // pins
  output logic                      quad_a_diff_out, // a-phase
  output logic                      quad_b_diff_out, // b-phase
  output logic                      zero_pulse_diff_out, // zero pulse, line driver
  output logic                      zero_pulse_oc_out,   // open-collector drive level, always 0
  output logic                      zero_pulse_oc_oe_n,  // low while transistor conducts
  output logic [MON_OUT_W-1:0]      monitor_ch1_out, // monitor 1 code, two's complement
  output logic [MON_OUT_W-1:0]      monitor_ch2_out  // monitor 2 code, two's complement
);
  // registers
  logic [31:0] ctrl_q;                               // phase and mode
  logic [31:0] pcnt_q;                               // output_pulse_count_cfg
  logic [31:0] gear_q;                               // output_pulse_gear_cfg
  logic [31:0] msel_q;                               // monitor selections
  // bus state
  logic [7:0]  awaddr_q;                             // held write address
  logic [31:0] wdata_q;                              // held write data
  logic [3:0]  wstrb_q;                              // held strobes
  logic        aw_got_q;                             // address captured
  logic        w_got_q;                              // data captured
  // motion state
  logic signed [33:0] acc_q;                         // scaling remainder
  logic signed [15:0] pend_q;                        // edges still owed, signed by direction
  logic [1:0]  phase_q;                              // quadrature step position
  logic [7:0]  gap_q;                                // cycles until next edge allowed
  logic        zero_pulse;                           // shaped zero pulse

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // write channel: address and data captured in either order, answer once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awaddr_q <= awaddr;
        aw_got_q <= 1'b1;
        awready  <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        w_got_q <= 1'b1;
        wready  <= 1'b0;
      end
      if (aw_got_q && w_got_q && !bvalid) begin
        bvalid <= 1'b1;
        case (awaddr_q)
          REG_CTRL, REG_PULSE_CNT, REG_PULSE_GEAR, REG_MON_SEL: bresp <= RESP_OKAY;
          default: bresp <= RESP_SLVERR;             // unmapped or read-only
        endcase
      end
      if (bvalid && bready) begin
        bvalid   <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        awready  <= 1'b1;
        wready   <= 1'b1;
      end
    end
  end

  // register store, committed in the cycle the response is raised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      pcnt_q <= PULSE_CNT_RST;
      gear_q <= PULSE_GEAR_RST;
      msel_q <= MON_SEL_RST;
    end else if (aw_got_q && w_got_q && !bvalid) begin
      case (awaddr_q)
        REG_CTRL:       ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
        REG_PULSE_CNT:  pcnt_q <= merge(pcnt_q, wdata_q, wstrb_q);
        REG_PULSE_GEAR: gear_q <= merge(gear_q, wdata_q, wstrb_q);
        REG_MON_SEL:    msel_q <= merge(msel_q, wdata_q, wstrb_q);
        default: ;                                   // nothing stored
      endcase
    end
  end

  // read channel: one access at a time, data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      case (araddr)
        REG_CTRL:       rdata <= ctrl_q;
        REG_PULSE_CNT:  rdata <= pcnt_q;
        REG_PULSE_GEAR: rdata <= gear_q;
        REG_MON_SEL:    rdata <= msel_q;
        REG_STATUS: begin
          rdata                     <= 32'h0;
          rdata[STAT_A_BIT]         <= quad_a_diff_out;
          rdata[STAT_B_BIT]         <= quad_b_diff_out;
          rdata[STAT_Z_BIT]         <= zero_pulse_diff_out;
          rdata[STAT_PEND_LSB +: 16] <= pend_q;
        end
        default: begin
          rdata <= 32'h0;
          rresp <= RESP_SLVERR;                      // unmapped address
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // scaling numerator and denominator by mode; a zero denominator acts as one
  logic [31:0] num;                                  // added per encoder count
  logic [31:0] den;                                  // one output edge per den
  always_comb begin
    case (scale_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]))
      MODE_COUNT: begin num = pcnt_q;  den = ENC_COUNTS_REV; end
      MODE_DIV:   begin num = 32'h1;   den = pcnt_q;         end
      MODE_GEAR:  begin num = pcnt_q;  den = gear_q;         end
      default:    begin num = 32'h1;   den = 32'h1;          end
    endcase
    if (den == 32'h0) begin
      den = 32'h1;
    end
  end

  // remainder accumulator: one edge owed or repaid per cycle while out of range, so
  // gear-up ratios spread over later cycles instead of needing a divider
  logic signed [33:0] acc_in;
  logic signed [33:0] den_s;
  always_comb begin
    den_s  = $signed({2'b00, den});
    acc_in = acc_q;
    if (enc_step) begin
      acc_in = enc_dir ? acc_q + $signed({2'b00, num}) : acc_q - $signed({2'b00, num});
    end
  end

  logic edge_go;                                     // an edge leaves this cycle
  assign edge_go = (gap_q == 8'h0) && (pend_q != 16'sh0);

  // accumulator and owed-edge count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q  <= 34'sh0;
      pend_q <= 16'sh0;
    end else begin
      logic signed [15:0] p;
      p = pend_q;
      if (edge_go) begin
        p = (pend_q > 16'sh0) ? pend_q - 16'sh1 : pend_q + 16'sh1;
      end
      if (acc_in >= den_s) begin
        acc_q  <= acc_in - den_s;
        pend_q <= (p == 16'sh7fff) ? p : p + 16'sh1;
      end else if (acc_in < 34'sh0) begin
        acc_q  <= acc_in + den_s;
        pend_q <= (p == -16'sh7fff) ? p : p - 16'sh1;
      end else begin
        acc_q  <= acc_in;
        pend_q <= p;
      end
    end
  end

  // rate limiter: edges spaced by at least the gap, so the ceiling holds at any ratio
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= 8'h0;
    end else if (edge_go) begin
      gap_q <= 8'(EDGE_GAP_CYC - 1);
    end else if (gap_q != 8'h0) begin
      gap_q <= gap_q - 8'h1;
    end
  end

  // quadrature position: up for positive owed edges, down for negative
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= 2'h0;
    end else if (edge_go) begin
      phase_q <= (pend_q > 16'sh0) ? phase_q + 2'h1 : phase_q - 2'h1;
    end
  end

  // gray mapping: counting up gives A leading; the swap flips the leading phase
  logic a_nx, b_nx;
  always_comb begin
    a_nx = phase_q[1] ^ phase_q[0];                  // 0,1,1,0 for steps 0..3
    b_nx = phase_q[1];                               // 0,0,1,1 lags a by one step
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quad_a_diff_out <= 1'b0;
      quad_b_diff_out <= 1'b0;
    end else if (ctrl_q[CTRL_PHASE_BIT]) begin
      quad_a_diff_out <= b_nx;
      quad_b_diff_out <= a_nx;
    end else begin
      quad_a_diff_out <= a_nx;
      quad_b_diff_out <= b_nx;
    end
  end

  zero_pulse_stretch #(
    .MIN_CYC (ZERO_MIN)
  ) u_zero (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .zero_level (enc_zero),
    .pulse_q    (zero_pulse)
  );

  // delayed by one stage, two registers after enc_zero, while the quadrature outputs sit three registers after enc_step;
  // both zero outputs come from the same pulse, so their timing matches exactly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_pulse_diff_out <= 1'b0;
      zero_pulse_oc_out   <= 1'b0;
      zero_pulse_oc_oe_n  <= 1'b1;
    end else begin
      zero_pulse_diff_out <= zero_pulse;
      zero_pulse_oc_out   <= 1'b0;
      zero_pulse_oc_oe_n  <= !zero_pulse;
    end
  end

  // monitor channels: top bits of the selected source, truncation toward minus infinity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_ch1_out <= '0;
      monitor_ch2_out <= '0;
    end else begin
      monitor_ch1_out <= mon_src[MON_SRC_W*msel_q[MON1_SEL_LSB +: 2] + MON_SRC_W - MON_OUT_W +: MON_OUT_W];
      monitor_ch2_out <= mon_src[MON_SRC_W*msel_q[MON2_SEL_LSB +: 2] + MON_SRC_W - MON_OUT_W +: MON_OUT_W];
    end
  end
endmodule : encoder_pulse_and_monitor_out
`default_nettype wire

// ===== enc_out_chk.sv
// checker for the encoder pulse block: edge spacing, zero pulse shape, monitor codes
// sees only the top module's ports; attached by the bind at the foot
`default_nettype none
module enc_out_chk
  import enc_out_pkg::*;
#(
  parameter int unsigned ZERO_MIN = ZERO_MIN_CYC     // zero pulse least width, cycles
) (
  input wire logic                   aclk,                // control clock
  input wire logic                   aresetn,             // synchronous reset, active low
  input wire logic                   enc_zero,            // zero position level
  input wire logic [4*MON_SRC_W-1:0] mon_src,             // monitor sources
  input wire logic                   quad_a_diff_out,     // a phase
  input wire logic                   quad_b_diff_out,     // b phase
  input wire logic                   zero_pulse_diff_out, // zero pulse
  input wire logic                   zero_pulse_oc_out,   // open-collector level
  input wire logic                   zero_pulse_oc_oe_n,  // low while transistor is on
  input wire logic [MON_OUT_W-1:0]   monitor_ch1_out,     // monitor 1 code
  input wire logic [MON_OUT_W-1:0]   monitor_ch2_out      // monitor 2 code
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] gap_q; // cycles since the last quadrature edge, saturating
  int         zhi_q; // cycles the zero pulse has stood high
  logic [1:0] run_q; // cycles since reset, saturating at 3
  // a reset counts as a long quiet spell, so the first edge after it is legal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= 8'hff;
      zhi_q <= 0;
      run_q <= 2'h0;
    end else begin
      gap_q <= (quad_a_diff_out != $past(quad_a_diff_out) || quad_b_diff_out != $past(quad_b_diff_out)) ? 8'h01 :
               (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
      zhi_q <= zero_pulse_diff_out ? zhi_q + 1 : 0;
      run_q <= (run_q == 2'h3) ? run_q : run_q + 2'h1;
    end
  end
  // true when the code is the top bits of one of the four sources
  function automatic logic in_set(input logic [MON_OUT_W-1:0] v, input logic [4*MON_SRC_W-1:0] s);
    in_set = 1'b0;
    for (int k = 0; k < 4; k++) if (s[MON_SRC_W*k+MON_SRC_W-MON_OUT_W +: MON_OUT_W] == v) in_set = 1'b1;
  endfunction : in_set
  property p_gap; ($changed(quad_a_diff_out) || $changed(quad_b_diff_out)) |-> gap_q >= EDGE_GAP_CYC; endproperty
  a_gap: assert property (p_gap) else $error("quadrature edges too close");
  property p_one_phase; !($changed(quad_a_diff_out) && $changed(quad_b_diff_out)); endproperty
  a_one_phase: assert property (p_one_phase) else $error("both phases moved at once");
  property p_oc_inv; zero_pulse_oc_oe_n == !zero_pulse_diff_out; endproperty
  a_oc_inv: assert property (p_oc_inv) else $error("open-collector zero timing differs");
  property p_oc_low; zero_pulse_oc_out == 1'b0; endproperty
  a_oc_low: assert property (p_oc_low) else $error("open-collector level not low");
  property p_zero_rise; $rose(enc_zero) |-> ##[1:2] zero_pulse_diff_out; endproperty
  a_zero_rise: assert property (p_zero_rise) else $error("zero pulse missing");
  property p_zero_cause; $rose(zero_pulse_diff_out) |-> $past(enc_zero) || $past(enc_zero, 2); endproperty
  a_zero_cause: assert property (p_zero_cause) else $error("zero pulse without zero position");
  property p_zero_width; $fell(zero_pulse_diff_out) |-> zhi_q >= ZERO_MIN; endproperty
  a_zero_width: assert property (p_zero_width) else $error("zero pulse too short");
  property p_mon1; ($stable(mon_src) && run_q == 2'h3) [*2] |-> in_set(monitor_ch1_out, mon_src); endproperty
  a_mon1: assert property (p_mon1) else $error("monitor 1 code not a source");
  property p_mon2; ($stable(mon_src) && run_q == 2'h3) [*2] |-> in_set(monitor_ch2_out, mon_src); endproperty
  a_mon2: assert property (p_mon2) else $error("monitor 2 code not a source");
endmodule : enc_out_chk
bind encoder_pulse_and_monitor_out enc_out_chk #(.ZERO_MIN(ZERO_MIN)) u_enc_out_chk (.aclk(aclk), .aresetn(aresetn),
  .enc_zero(enc_zero), .mon_src(mon_src), .quad_a_diff_out(quad_a_diff_out), .quad_b_diff_out(quad_b_diff_out),
  .zero_pulse_diff_out(zero_pulse_diff_out), .zero_pulse_oc_out(zero_pulse_oc_out),
  .zero_pulse_oc_oe_n(zero_pulse_oc_oe_n), .monitor_ch1_out(monitor_ch1_out), .monitor_ch2_out(monitor_ch2_out));
`default_nettype wire

// ===== enc_ctrl_model.sv
// positioning controller model: counts quadrature edges and zero pulses
// assumes its lines are sampled on the block's own clock
`default_nettype none
module enc_ctrl_model (
  input  wire logic aclk,    // sampling clock
  input  wire logic aresetn, // clears the counters, active low
  input  wire logic qa,      // a phase line
  input  wire logic qb,      // b phase line
  input  wire logic zp,      // zero pulse line
  output var  int   pos,     // signed position, up when a leads
  output var  int   zcnt,    // zero pulses counted
  output var  int   zlen,    // width of the last zero pulse
  output var  int   bad      // double jumps, i.e. lost edges
);
  logic [1:0] pv_q;  // gray index of the last state
  logic       zp_q;  // zero line one cycle ago
  int         run_q; // zero pulse length so far
  // gray index: 00, 10, 11, 01 counts up when a leads
  function automatic logic [1:0] gidx(input logic a, input logic b);
    return {b, a ^ b};
  endfunction : gidx
  // decoded like a 4x counter in a real controller
  always @(posedge aclk) begin
    if (!aresetn) begin
      {pos, zcnt, zlen, bad, run_q} <= '0;
      pv_q <= 2'h0;
      zp_q <= 1'b0;
    end else begin
      case (2'(gidx(qa, qb) - pv_q))
        2'h1: pos <= pos + 1;
        2'h3: pos <= pos - 1;
        2'h2: bad <= bad + 1;
        default: ;
      endcase
      pv_q <= gidx(qa, qb);
      zp_q <= zp;
      run_q <= zp ? run_q + 1 : 0;
      if (zp_q && !zp) begin
        zcnt <= zcnt + 1;
        zlen <= run_q;
      end
    end
  end
endmodule : enc_ctrl_model
`default_nettype wire

// ===== encoder_pulse_and_monitor_out_tb_top.sv
// self-checking bench for the encoder pulse block with a controller model
// assumes the package and both design modules are compiled first
`default_nettype none
module encoder_pulse_and_monitor_out_tb_top import enc_out_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REV = 16;  // shortened counts per revolution
  localparam int ZMIN = 20; // shortened zero pulse width
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic enc_step = 0, enc_dir = 0, enc_zero = 0, awready, wready, bvalid, arready, rvalid, qa, qb, zd, zo, zoe;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, rs;
  logic [4*MON_SRC_W-1:0] mon_src = '0;
  logic [MON_OUT_W-1:0] m1, m2;
  int pos, zcnt, zlen, bad, errors = 0, n_compared = 0;
  always #4 aclk = ~aclk;
  encoder_pulse_and_monitor_out #(.ENC_COUNTS_REV(REV), .ZERO_MIN(ZMIN)) u_encoder_pulse_and_monitor_out (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .enc_step(enc_step), .enc_dir(enc_dir), .enc_zero(enc_zero), .mon_src(mon_src),
    .quad_a_diff_out(qa), .quad_b_diff_out(qb), .zero_pulse_diff_out(zd), .zero_pulse_oc_out(zo),
    .zero_pulse_oc_oe_n(zoe), .monitor_ch1_out(m1), .monitor_ch2_out(m2));
  enc_ctrl_model u_enc_ctrl_model (.aclk(aclk), .aresetn(aresetn), .qa(qa), .qb(qb), .zp(zd), .pos(pos),
    .zcnt(zcnt), .zlen(zlen), .bad(bad));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic rst();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : rst
  // address and data go out together; each is dropped at its own handshake;
  // bready and rready stay high afterwards, so back-to-back calls never drive them twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad = 0, wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask : wr
  task automatic rd_(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : rd_
  task automatic cfg(input logic [31:0] ctrl, input logic [31:0] cnt, input logic [31:0] gear);
    rst();
    wr(REG_CTRL, ctrl, rs);
    wr(REG_PULSE_CNT, cnt, rs);
    wr(REG_PULSE_GEAR, gear, rs);
  endtask : cfg
  // paced steps, spaced wider than the output edge gap
  task automatic steps(input int n, input logic d);
    repeat (n) begin
      enc_dir <= d;
      enc_step <= 1'b1;
      @(posedge aclk);
      enc_step <= 1'b0;
      repeat (40) @(posedge aclk);
    end
  endtask : steps
  task automatic t_regs();
    logic [7:0] a[4] = '{REG_CTRL, REG_PULSE_CNT, REG_PULSE_GEAR, REG_MON_SEL};
    logic [31:0] e[4] = '{CTRL_RST, PULSE_CNT_RST, PULSE_GEAR_RST, MON_SEL_RST};
    for (int i = 0; i < 4; i++) begin
      rd_(a[i], rd, rs);
      chk("reset value", rd, e[i]);
    end
    wr(REG_PULSE_GEAR, 32'h0000_0007, rs);
    rd_(REG_PULSE_GEAR, rd, rs);
    chk("gear readback", rd, 32'h0000_0007);
    wr(REG_STATUS, 32'h0000_0001, rs);
    chk("status write resp", rs, RESP_SLVERR);
    rd_(8'h14, rd, rs);
    chk("unmapped read resp", rs, RESP_SLVERR);
  endtask : t_regs
  // i[0] is the direction, i[1] the phase swap
  task automatic t_dir();
    for (int i = 0; i < 4; i++) begin
      cfg({31'h0, i[1]}, REV, 1);
      steps(4, i[0]);
      repeat (60) @(posedge aclk);
      chk("direction", pos, (i[0] ^ i[1]) ? 4 : -4);
      chk("lost edges", bad, 0);
      rd_(REG_STATUS, rd, rs);
      chk("status at rest", rd, 32'h0);
    end
  endtask : t_dir
  task automatic t_scale();
    logic [31:0] cnt[3] = '{REV, 2, 3};
    logic [31:0] gr[3] = '{1, 1, 2};
    int exp[3] = '{8, 4, 12};
    for (int i = 0; i < 3; i++) begin
      cfg(i << CTRL_MODE_LSB, cnt[i], gr[i]);
      steps(8, 1'b1);
      repeat (300) @(posedge aclk);
      chk("scaled count", pos, exp[i]);
    end
  endtask : t_scale
  // eight back-to-back steps must drain no faster than the edge ceiling
  task automatic t_rate();
    int t = 8;
    cfg(0, REV, 1);
    enc_dir <= 1'b1;
    enc_step <= 1'b1;
    repeat (8) @(posedge aclk);
    enc_step <= 1'b0;
    while (pos < 8 && t < 1000) begin
      @(posedge aclk);
      t++;
    end
    chk("burst edges", pos, 8);
    chk("burst slow enough", t >= 7 * EDGE_GAP_CYC, 1);
  endtask : t_rate
  task automatic t_zero();
    cfg(0, REV, 1);
    enc_zero <= 1'b1;
    repeat (3) @(posedge aclk);
    enc_zero <= 1'b0;
    repeat (ZMIN + 10) @(posedge aclk);
    chk("zero count", zcnt, 1);
    chk("short pulse stretched", zlen >= ZMIN, 1);
    enc_zero <= 1'b1;
    repeat (2 * ZMIN) @(posedge aclk);
    enc_zero <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("zero count", zcnt, 2);
    chk("long pulse follows level", zlen >= 2 * ZMIN - 2, 1);
  endtask : t_zero
  task automatic t_mon();
    logic [MON_OUT_W-1:0] me[4] = '{10'h3f9, 10'h048, 10'h1ff, 10'h200}; // top ten bits of sources 0..3
    mon_src <= {16'h8000, 16'h7fc0, 16'h1234, 16'hfe40};
    for (int s = 0; s < 4; s++) begin
      wr(REG_MON_SEL, s | ((3 - s) << MON2_SEL_LSB), rs);
      repeat (4) @(posedge aclk);
      chk("monitor 1", m1, me[s]);
      chk("monitor 2", m2, me[3 - s]);
    end
  endtask : t_mon
  initial begin
    rst();
    t_regs();
    t_dir();
    t_scale();
    t_rate();
    t_zero();
    t_mon();
    wrap_up();
  end
  // watchdog, well beyond the few thousand cycles the run needs
  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    wrap_up();
  end
endmodule : encoder_pulse_and_monitor_out_tb_top
`default_nettype wire
